/* File: design/shap_device.sv */
// Device end of the serial host-access port: SPI and I2C slave
`timescale 1ns/1ps
// Summary of operation
// - Host write clock at most mclk/3
// - Host read clock at most mclk/6
// - Data sampled on host clock while selected
// - First byte top bits choose cycle
// - Select held low for whole transfer
// - Second byte: host writes, device reads out
// - Four-wire mode uses separate in/out lines
// - I2C runs at 100K or 400K only
// - I2C address: 6-bit id, cycle select
// - Select 1 command/status, 0 data
// - Id is zero plus two strap bits
// - Select and direction give four cycles
// - Command then data write stores register
// - Command then data read returns register
// - Address 02h opens streaming memory access
// - Host never mixes memory reads and writes
// - First memory read is a dummy
// - Interrupt and busy outputs active low
// - Status bits 0..2 set by events
// - Status flags clear only by writing 1
// - Enables gate only the interrupt pin
// - Busy during font, clear, block transfer
// - Status bits 3,4 set, write-1 clears
module shap_device (
  input  logic                 mclk,
  input  logic                 reset_n,
  input  shap_pkg::link_mode_t link_mode,
  input  logic [1:0]           bus_id_strap,
  input  logic [7:0]           core_status,
  input  logic                 busy_font,
  input  logic                 busy_clear,
  input  logic                 busy_bte,
  input  logic [4:0]           irq_events,
  output logic [7:0]           reg_addr,
  output logic [7:0]           wr_data,
  output logic                 reg_wr,
  input  logic [7:0]           reg_rdata,
  output logic                 mem_wr,
  output logic                 mem_rd_req,
  input  logic                 mem_rd_valid,
  input  logic [7:0]           mem_rd_data,
  output logic                 irq_n,
  output logic                 wait_n,
  shap_link_if.device          link
);
  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_WR   = 2'b10,
    I_RD   = 2'b11
  } i2c_state_t;

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [1:0] id1_q;
  logic [1:0] id2_q;
  logic       sck;
  logic       cs_n;
  logic       sda;
  logic       sck_rise;
  logic       sck_fall;
  logic       din;
  logic       is_i2c;
  logic [7:0] spi_byte;
  logic [4:0] spi_cnt_q;
  logic [7:0] spi_sh_q;
  logic [7:0] spi_tx_q;
  logic [7:0] spi_wd_q;
  logic       spi_rs_q;
  logic       spi_rw_q;
  logic       spi_out_q;
  logic       spi_oe_q;
  logic       spi_wr_q;
  logic       spi_rd_q;
  i2c_state_t i2c_st_q;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_sh_q;
  logic [7:0] i2c_tx_q;
  logic [7:0] i2c_next;
  logic       i2c_rs_q;
  logic       i2c_rw_q;
  logic       i2c_nack_q;
  logic       i2c_rel_q;
  logic       i2c_wr_q;
  logic       i2c_rd_q;
  logic       wr_go;
  logic       wr_rs;
  logic [7:0] wr_byte;
  logic       rd_go;
  logic       rd_rs;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic       mem_mode_q;
  logic       mem_wr_q;
  logic       reg_wr_q;
  logic       mem_rd_req_q;
  logic [7:0] rd_buf_q;
  logic [4:0] irq_en_q;
  logic [4:0] irq_st_q;
  logic [4:0] st_clr;
  logic       busy;
  logic       irq_n_q;
  logic       wait_n_q;
  logic       sdo_q;
  logic       sda_o_q;
  logic       sda_oe_n_q;

  // Byte returned by a read cycle of the given type
  function automatic logic [7:0] rd_byte(input logic rs);
    if (rs) begin
      return core_status;
    end else if (mem_mode_q) begin
      return rd_buf_q;
    end else if (addr_q == shap_pkg::REG_IRQ_EN) begin
      return {3'h0, irq_en_q};
    end else if (addr_q == shap_pkg::REG_IRQ_ST) begin
      return {3'h0, irq_st_q};
    end else begin
      return reg_rdata;
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk) begin
    s1_q  <= {link.sck, link.host_select_n, link.sdi, link.sda};
    s2_q  <= s1_q;
    s3_q  <= s2_q;
    id1_q <= bus_id_strap;
    id2_q <= id1_q;
  end

  assign sck      = s2_q[3];
  assign cs_n     = s2_q[2];
  assign sda      = s2_q[0];
  assign sck_rise = sck & ~s3_q[3];
  assign sck_fall = ~sck & s3_q[3];
  assign is_i2c   = (link_mode == shap_pkg::MODE_I2C);
  assign din      = (link_mode == shap_pkg::MODE_SPI4) ? s2_q[1] : sda;
  assign spi_byte = {spi_sh_q[6:0], din};

  // ****************************************
  // SPI slave
  // ****************************************
  // Ignores the clock while deselected, so a bad frame dies at release
  always_ff @(posedge mclk) begin
    spi_wr_q <= 1'b0;
    spi_rd_q <= 1'b0;
    if (!reset_n || is_i2c || cs_n) begin
      spi_cnt_q <= 5'h00;
      spi_out_q <= 1'b1;
      spi_oe_q  <= 1'b0;
      spi_rs_q  <= 1'b0;
      spi_rw_q  <= 1'b0;
    end else if (sck_rise) begin
      spi_sh_q <= spi_byte;
      if (spi_cnt_q != 5'h10) begin
        spi_cnt_q <= spi_cnt_q + 5'h01;
      end
      if (spi_cnt_q == 5'h07) begin
        spi_rs_q <= spi_byte[shap_pkg::SPI_RS_B];
        spi_rw_q <= spi_byte[shap_pkg::SPI_RW_B];
        if (spi_byte[shap_pkg::SPI_RW_B]) begin
          spi_tx_q <= rd_byte(spi_byte[shap_pkg::SPI_RS_B]);
          spi_rd_q <= 1'b1;
        end
      end
      if (spi_cnt_q == 5'h0f && !spi_rw_q) begin
        spi_wd_q <= spi_byte;
        spi_wr_q <= 1'b1;
      end
    end else if (sck_fall && spi_rw_q && spi_cnt_q[3] && !spi_cnt_q[4]) begin
      spi_out_q <= spi_tx_q[7];
      spi_tx_q  <= {spi_tx_q[6:0], 1'b0};
      spi_oe_q  <= 1'b1;
    end
  end

  // ****************************************
  // I2C slave
  // ****************************************
  assign i2c_next = (i2c_st_q == I_RD) ? rd_byte(i2c_rs_q) : i2c_tx_q;

  // No clock stretching: a read byte is fetched within one mclk
  always_ff @(posedge mclk) begin
    i2c_wr_q <= 1'b0;
    i2c_rd_q <= 1'b0;
    if (!reset_n || !is_i2c) begin
      i2c_st_q  <= I_IDLE;
      i2c_cnt_q <= 4'h0;
      i2c_rel_q <= 1'b1;
      i2c_rs_q  <= 1'b0;
      i2c_rw_q  <= 1'b0;
    end else if (sck && s3_q[3] && s3_q[0] && !sda) begin
      i2c_st_q  <= I_ADDR;
      i2c_cnt_q <= 4'h0;
      i2c_rel_q <= 1'b1;
    end else if (sck && s3_q[3] && !s3_q[0] && sda) begin
      i2c_st_q  <= I_IDLE;
      i2c_rel_q <= 1'b1;
    end else if (i2c_st_q != I_IDLE && sck_rise) begin
      if (i2c_cnt_q < 4'h8) begin
        i2c_sh_q <= {i2c_sh_q[6:0], sda};
      end
      if (i2c_cnt_q == 4'h8) begin
        i2c_nack_q <= sda;
      end
      i2c_cnt_q <= i2c_cnt_q + 4'h1;
    end else if (i2c_st_q != I_IDLE && sck_fall) begin
      if (i2c_cnt_q == 4'h8) begin
        i2c_rel_q <= 1'b1;
        case (i2c_st_q)
          I_ADDR: begin
            if (i2c_sh_q[7:2] == {shap_pkg::ID_UPPER, id2_q}) begin
              i2c_rel_q <= 1'b0;
              i2c_rs_q  <= i2c_sh_q[1];
              i2c_rw_q  <= i2c_sh_q[0];
              if (i2c_sh_q[0]) begin
                i2c_tx_q <= rd_byte(i2c_sh_q[1]);
                i2c_rd_q <= 1'b1;
              end
            end else begin
              i2c_st_q <= I_IDLE;
            end
          end
          I_WR: begin
            i2c_rel_q <= 1'b0;
            i2c_wr_q  <= 1'b1;
          end
          default: begin
          end
        endcase
      end else if (i2c_cnt_q == 4'h9) begin
        i2c_cnt_q <= 4'h0;
        if (i2c_st_q == I_RD && i2c_nack_q) begin
          i2c_st_q  <= I_IDLE;
          i2c_rel_q <= 1'b1;
        end else if (i2c_rw_q) begin
          i2c_st_q  <= I_RD;
          i2c_rel_q <= i2c_next[7];
          i2c_tx_q  <= {i2c_next[6:0], 1'b0};
          i2c_rd_q  <= (i2c_st_q == I_RD);
        end else begin
          i2c_st_q  <= I_WR;
          i2c_rel_q <= 1'b1;
        end
      end else if (i2c_st_q == I_RD) begin
        i2c_rel_q <= i2c_tx_q[7];
        i2c_tx_q  <= {i2c_tx_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Cycle executor and registers
  // ****************************************
  assign wr_go   = spi_wr_q | i2c_wr_q;
  assign wr_rs   = is_i2c ? i2c_rs_q : spi_rs_q;
  assign wr_byte = is_i2c ? i2c_sh_q : spi_wd_q;
  assign rd_go   = spi_rd_q | i2c_rd_q;
  assign rd_rs   = is_i2c ? i2c_rs_q : spi_rs_q;
  assign busy    = busy_font | busy_clear | busy_bte;

  always_ff @(posedge mclk) begin
    mem_wr_q     <= 1'b0;
    reg_wr_q     <= 1'b0;
    mem_rd_req_q <= 1'b0;
    if (!reset_n) begin
      addr_q     <= 8'h00;
      wdata_q    <= 8'h00;
      mem_mode_q <= 1'b0;
      irq_en_q   <= shap_pkg::IRQ_EN_RST;
    end else if (wr_go && wr_rs) begin
      addr_q     <= wr_byte;
      mem_mode_q <= (wr_byte == shap_pkg::REG_MEM);
    end else if (wr_go) begin
      wdata_q <= wr_byte;
      if (mem_mode_q) begin
        mem_wr_q <= !busy;
      end else if (addr_q == shap_pkg::REG_IRQ_EN) begin
        irq_en_q <= wr_byte[4:0];
      end else if (addr_q != shap_pkg::REG_IRQ_ST) begin
        reg_wr_q <= 1'b1;
      end
    end else if (rd_go && !rd_rs && mem_mode_q) begin
      mem_rd_req_q <= 1'b1;
    end
  end

  // Read data trails one read behind, so the first read is a dummy
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_buf_q <= 8'h00;
    end else if (mem_rd_valid) begin
      rd_buf_q <= mem_rd_data;
    end
  end

  assign st_clr = (wr_go && !wr_rs && !mem_mode_q && addr_q == shap_pkg::REG_IRQ_ST) ?
                  wr_byte[4:0] : 5'h00;

  // An event in the clearing cycle survives the clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_st_q <= shap_pkg::IRQ_ST_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~st_clr) | irq_events;
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_n_q    <= 1'b1;
      wait_n_q   <= 1'b1;
      sdo_q      <= 1'b1;
      sda_o_q    <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      irq_n_q    <= ~|(irq_st_q & irq_en_q);
      wait_n_q   <= ~busy;
      sdo_q      <= spi_out_q;
      sda_o_q    <= is_i2c ? 1'b0 : spi_out_q;
      sda_oe_n_q <= is_i2c ? i2c_rel_q : ~(spi_oe_q && link_mode == shap_pkg::MODE_SPI3);
    end
  end

  assign irq_n             = irq_n_q;
  assign wait_n            = wait_n_q;
  assign reg_addr          = addr_q;
  assign wr_data           = wdata_q;
  assign reg_wr            = reg_wr_q;
  assign mem_wr            = mem_wr_q;
  assign mem_rd_req        = mem_rd_req_q;
  assign link.sdo          = sdo_q;
  assign link.dev_sda_o    = sda_o_q;
  assign link.dev_sda_oe_n = sda_oe_n_q;
endmodule

/* File: design/shap_pkg.sv */
// Shared constants and types for the serial host-access port
package shap_pkg;
  // ****************************************
  // Clock and link timing
  // ****************************************
  localparam int unsigned MCLK_HZ     = 10_000_000;
  localparam int unsigned SPI_SCK_NS  = 800;
  localparam int unsigned I2C_STD_HZ  = 100_000;
  localparam int unsigned I2C_FAST_HZ = 400_000;
  // Half periods of the host-made serial clock, in mclk cycles
  localparam logic [5:0] SPI_HALF =
    6'((SPI_SCK_NS * (MCLK_HZ / 1_000_000)) / 2_000);
  // Rounded up, so the bus never runs above its nominal rate
  localparam logic [5:0] I2C_HALF_STD  =
    6'((MCLK_HZ + 2 * I2C_STD_HZ - 1) / (2 * I2C_STD_HZ));
  localparam logic [5:0] I2C_HALF_FAST =
    6'((MCLK_HZ + 2 * I2C_FAST_HZ - 1) / (2 * I2C_FAST_HZ));
  // Data moves this far into a low phase, clear of the clock edge
  localparam logic [5:0] DATA_DLY = 6'h02;

  // ****************************************
  // Link modes and access cycles
  // ****************************************
  typedef enum logic [1:0] {
    MODE_SPI3 = 2'b00,
    MODE_SPI4 = 2'b01,
    MODE_I2C  = 2'b10
  } link_mode_t;
  // Encoded as {cycle_type_select, read}
  typedef enum logic [1:0] {
    CYC_DATA_WR = 2'b00,
    CYC_DATA_RD = 2'b01,
    CYC_CMD_WR  = 2'b10,
    CYC_STAT_RD = 2'b11
  } cyc_t;
  localparam int SPI_RS_B = 7;
  localparam int SPI_RW_B = 6;
  localparam logic [4:0] SPI_LAST = 5'h0f;
  localparam logic [4:0] I2C_LAST = 5'h11;
  localparam logic [3:0] ID_UPPER = 4'h0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_MEM    = 8'h02;
  localparam logic [7:0] REG_IRQ_EN = 8'hf0;
  localparam logic [7:0] REG_IRQ_ST = 8'hf1;
  localparam logic [4:0] IRQ_EN_RST = 5'h00;
  localparam logic [4:0] IRQ_ST_RST = 5'h00;
endpackage

/* File: design/shap_link_if.sv */
// Serial link between the host-access port and its host
`timescale 1ns/1ps
interface shap_link_if;
  logic sck;
  logic host_select_n;
  logic sdi;
  logic sdo;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic sda;

  // Pulled-up shared line; a released end reads as high
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

  modport device (
    input  sck, host_select_n, sdi, sda,
    output sdo, dev_sda_o, dev_sda_oe_n
  );
  modport host (
    output sck, host_select_n, sdi, host_sda_o, host_sda_oe_n,
    input  sdo, sda
  );
endinterface

/* File: design/shap_host.sv */
// Host end of the serial host-access port: SPI and I2C master
`timescale 1ns/1ps
module shap_host (
  input  logic                 mclk,
  input  logic                 reset_n,
  input  shap_pkg::link_mode_t link_mode,
  input  logic                 i2c_fast,
  input  logic [1:0]           target_id,
  input  logic                 req_valid,
  input  shap_pkg::cyc_t       req_cyc,
  input  logic [7:0]           req_wdata,
  output logic                 req_ready,
  output logic                 rsp_valid,
  output logic [7:0]           rsp_rdata,
  output logic                 rsp_nack,
  shap_link_if.host            link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_LO   = 3'b010,
    H_HI   = 3'b011,
    H_TAIL = 3'b100,
    H_STOP = 3'b101
  } host_state_t;

  host_state_t st_q;
  logic [5:0]  div_q;
  logic [5:0]  half;
  logic        tick;
  logic        set_pt;
  logic        is_i2c;
  logic [1:0]  in1_q;
  logic [1:0]  in2_q;
  logic        rx_bit;
  logic [4:0]  idx_q;
  logic [4:0]  last;
  logic [7:0]  hdr_q;
  logic [7:0]  wd_q;
  logic        rw_q;
  logic [7:0]  rx_q;
  logic        nack_q;
  logic        rsp_q;
  logic        drv;
  logic        val;
  logic        sck_q;
  logic        cs_n_q;
  logic        sdi_q;
  logic        sda_o_q;
  logic        sda_oe_n_q;

  assign is_i2c = (link_mode == shap_pkg::MODE_I2C);
  assign last   = is_i2c ? shap_pkg::I2C_LAST : shap_pkg::SPI_LAST;

  // ****************************************
  // Serial clock divider
  // ****************************************
  // 800 ns SPI period keeps well under mclk/6 of the device
  assign half = !is_i2c ? shap_pkg::SPI_HALF :
                i2c_fast ? shap_pkg::I2C_HALF_FAST : shap_pkg::I2C_HALF_STD;
  assign tick   = (st_q != H_IDLE) && (div_q == half - 6'h01);
  assign set_pt = (div_q == shap_pkg::DATA_DLY) && (st_q == H_LO || st_q == H_TAIL);

  always_ff @(posedge mclk) begin
    if (!reset_n || st_q == H_IDLE || tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    in1_q <= {link.sdo, link.sda};
    in2_q <= in1_q;
  end
  assign rx_bit = (link_mode == shap_pkg::MODE_SPI4) ? in2_q[1] : in2_q[0];

  // ****************************************
  // Bit to put on the line
  // ****************************************
  always_comb begin
    drv = 1'b1;
    val = 1'b1;
    if (idx_q < 5'h08) begin
      val = hdr_q[3'h7 - idx_q[2:0]];
    end else if (!is_i2c && !rw_q) begin
      val = wd_q[3'h7 - idx_q[2:0]];
    end else if (is_i2c && !rw_q && idx_q > 5'h08 && idx_q < 5'h11) begin
      val = wd_q[3'(5'h10 - idx_q)];
    end else begin
      drv = 1'b0;
    end
  end

  // ****************************************
  // Frame sequencer
  // ****************************************
  always_ff @(posedge mclk) begin
    rsp_q <= 1'b0;
    if (!reset_n) begin
      st_q       <= H_IDLE;
      idx_q      <= 5'h00;
      sck_q      <= 1'b0;
      cs_n_q     <= 1'b1;
      sdi_q      <= 1'b0;
      sda_o_q    <= 1'b1;
      sda_oe_n_q <= 1'b1;
      nack_q     <= 1'b0;
      rw_q       <= 1'b0;
    end else begin
      case (st_q)
        H_IDLE: begin
          sck_q <= is_i2c;
          if (req_valid) begin
            st_q   <= H_LEAD;
            idx_q  <= 5'h00;
            nack_q <= 1'b0;
            rw_q   <= req_cyc[0];
            wd_q   <= req_wdata;
            hdr_q  <= is_i2c ? {shap_pkg::ID_UPPER, target_id, req_cyc} :
                               {req_cyc, 6'h00};
            if (is_i2c) begin
              sda_o_q    <= 1'b0;
              sda_oe_n_q <= 1'b0;
            end else begin
              cs_n_q <= 1'b0;
            end
          end
        end
        H_LEAD: begin
          if (tick) begin
            st_q  <= H_LO;
            sck_q <= 1'b0;
          end
        end
        H_LO: begin
          if (set_pt) begin
            sdi_q      <= val;
            sda_o_q    <= val;
            // Open drain on I2C: a one is a release, never a push
            sda_oe_n_q <= ~(drv && link_mode != shap_pkg::MODE_SPI4) | (is_i2c & val);
          end
          if (tick) begin
            st_q  <= H_HI;
            sck_q <= 1'b1;
          end
        end
        H_HI: begin
          if (tick) begin
            sck_q <= 1'b0;
            if ((!is_i2c && idx_q[3]) || (is_i2c && idx_q > 5'h08 && idx_q < 5'h11)) begin
              rx_q <= {rx_q[6:0], rx_bit};
            end
            if (is_i2c && rx_bit && (idx_q == 5'h08 || (idx_q == last && !rw_q))) begin
              nack_q <= 1'b1;
            end
            if (idx_q == last || (is_i2c && rx_bit && idx_q == 5'h08)) begin
              st_q <= H_TAIL;
            end else begin
              st_q  <= H_LO;
              idx_q <= idx_q + 5'h01;
            end
          end
        end
        H_TAIL: begin
          if (set_pt && is_i2c) begin
            sda_o_q    <= 1'b0;
            sda_oe_n_q <= 1'b0;
          end
          // SPI stays deselected a half period so the device frees the line
          if (tick && !is_i2c) begin
            st_q       <= H_STOP;
            cs_n_q     <= 1'b1;
            sda_oe_n_q <= 1'b1;
          end else if (tick) begin
            st_q  <= H_STOP;
            sck_q <= 1'b1;
          end
        end
        H_STOP: begin
          if (tick) begin
            st_q       <= H_IDLE;
            sda_o_q    <= 1'b1;
            sda_oe_n_q <= 1'b1;
            rsp_q      <= 1'b1;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  assign req_ready          = (st_q == H_IDLE);
  assign rsp_valid          = rsp_q;
  assign rsp_rdata          = rx_q;
  assign rsp_nack           = nack_q;
  assign link.sck           = sck_q;
  assign link.host_select_n = cs_n_q;
  assign link.sdi           = sdi_q;
  assign link.host_sda_o    = sda_o_q;
  assign link.host_sda_oe_n = sda_oe_n_q;
endmodule

/* File: dv/shap_checker.sv */
// Link-side assertions for the serial host-access port
`timescale 1ns/1ps
module shap_checker (
  input logic mclk,
  input logic reset_n,
  input logic sck,
  input logic host_select_n,
  input logic sdi,
  input logic sdo,
  input logic dev_sda_o,
  input logic dev_sda_oe_n,
  input logic host_sda_o,
  input logic host_sda_oe_n,
  input logic sda
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // ****************
  // Frame bit count
  // ****************
  logic [4:0] rise_q;
  logic       sck_q;
  always_ff @(posedge mclk) begin
    sck_q <= sck;
  end
  // Cleared while deselected, so the value at deselect is the frame's count
  always_ff @(posedge mclk) begin
    if (!reset_n || host_select_n) begin
      rise_q <= 5'h00;
    end else if (sck && !sck_q) begin
      rise_q <= rise_q + 5'h01;
    end
  end

  // ****************
  // Wire rules
  // ****************
  a_sck_high_min: assert property ($rose(sck) |-> sck[*3])
    else $error("serial clock high phase too short");
  a_sck_low_min: assert property ($fell(sck) |-> !sck[*3])
    else $error("serial clock low phase too short");
  a_select_lead: assert property ($fell(host_select_n) |-> !sck[*4])
    else $error("clock started too soon after select");
  a_frame_bits: assert property ($rose(host_select_n) |-> rise_q == 5'h10)
    else $error("select released before sixteen clocks");
  // Two cycles of slack: device output follows a synchronised clock
  a_sda_held: assert property ((!host_select_n && sck && $past(sck) && $past(sck, 2))
    |-> $stable(sda))
    else $error("data line moved while clock high");
  a_sdi_held: assert property ((!host_select_n && sck && $past(sck)) |-> $stable(sdi))
    else $error("input line moved while clock high");
  a_sdo_held: assert property ((!host_select_n && sck && $past(sck) && $past(sck, 2))
    |-> $stable(sdo))
    else $error("output line moved while clock high");
  a_device_waits: assert property ((!host_select_n && rise_q < 5'h08) |-> dev_sda_oe_n)
    else $error("device drove data during first byte");
  a_no_clash: assert property ((!dev_sda_oe_n && !host_sda_oe_n)
    |-> !(dev_sda_o || host_sda_o))
    else $error("both ends drive data line");

  c_spi_frame: cover property ($rose(host_select_n) && rise_q == 5'h10);
  c_spi_readout: cover property ($fell(dev_sda_oe_n) && !host_select_n);
  c_i2c_ack: cover property ($fell(dev_sda_oe_n) && host_select_n);
endmodule

/* File: dv/serial_host_access_port_bench.sv */
// Bench joining the host and device ends over one serial link
`timescale 1ns/1ps
module serial_host_access_port_bench;
  logic                 mclk, reset_n, i2c_fast, req_valid, req_ready, rsp_valid;
  logic                 rsp_nack, reg_wr, mem_wr, mem_rd_req, mem_rd_valid, irq_n;
  logic                 wait_n, busy_font, busy_clear, busy_bte;
  logic [1:0]           tid, wp, rp;
  logic [4:0]           irq_events;
  logic [7:0]           wdata, rdata, rsp_rdata, core_status, reg_addr, wr_data;
  logic [7:0]           reg_rdata, mem_rd_data;
  logic [7:0]           regs [256];
  logic [7:0]           mem [4];
  logic [7:0]           rd_exp [3] = '{8'h11, 8'h22, 8'hee};
  shap_pkg::link_mode_t mode;
  shap_pkg::cyc_t       cyc;
  int                   failures, check_count;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************
  // Core stand-in
  // ****************
  assign reg_rdata = regs[reg_addr];
  always @(posedge mclk) begin
    mem_rd_valid <= mem_rd_req;
    mem_rd_data <= mem[rp];
    if (reg_wr) regs[reg_addr] <= wr_data;
    if (mem_wr) mem[wp] <= wr_data;
    wp <= !reset_n ? 2'h0 : wp + 2'(mem_wr);
    rp <= !reset_n ? 2'h0 : rp + 2'(mem_rd_req);
  end

  shap_link_if shap_link_if_i ();
  shap_device shap_device_i (.mclk, .reset_n, .link_mode(mode), .bus_id_strap(2'b10),
    .core_status, .busy_font, .busy_clear, .busy_bte, .irq_events, .reg_addr, .wr_data,
    .reg_wr, .reg_rdata, .mem_wr, .mem_rd_req, .mem_rd_valid, .mem_rd_data, .irq_n,
    .wait_n, .link(shap_link_if_i));
  shap_host shap_host_i (.mclk, .reset_n, .link_mode(mode), .i2c_fast, .target_id(tid),
    .req_valid, .req_cyc(cyc), .req_wdata(wdata), .req_ready, .rsp_valid, .rsp_rdata,
    .rsp_nack, .link(shap_link_if_i));
  shap_checker shap_checker_i (.mclk, .reset_n, .sck(shap_link_if_i.sck),
    .host_select_n(shap_link_if_i.host_select_n), .sdi(shap_link_if_i.sdi),
    .sdo(shap_link_if_i.sdo), .dev_sda_o(shap_link_if_i.dev_sda_o),
    .dev_sda_oe_n(shap_link_if_i.dev_sda_oe_n), .host_sda_o(shap_link_if_i.host_sda_o),
    .host_sda_oe_n(shap_link_if_i.host_sda_oe_n), .sda(shap_link_if_i.sda));

  // ****************
  // Tasks
  // ****************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rst();
    reset_n = 1'b0;
    tick(8);
    reset_n = 1'b1;
  endtask
  // One whole frame; the slowest link frame is some 2000 cycles
  task automatic xfer(input shap_pkg::cyc_t c, input logic [7:0] d);
    int n;
    tick(1);
    cyc = c;
    wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 9) begin
      tick(1);
      n++;
    end
    tick(1);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    if (n >= 4000) begin
      failures++;
      report_and_stop();
    end
    rdata = rsp_rdata;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    xfer(shap_pkg::CYC_CMD_WR, a);
    xfer(shap_pkg::CYC_DATA_WR, d);
  endtask
  task automatic rreg(input logic [7:0] a);
    xfer(shap_pkg::CYC_CMD_WR, a);
    xfer(shap_pkg::CYC_DATA_RD, 8'h00);
  endtask

  // Span is about twice the expected run
  initial begin
    #9_000_000;
    failures++;
    report_and_stop();
  end

  initial begin
    {reset_n, req_valid, busy_font, busy_clear, busy_bte} = 5'h00;
    {i2c_fast, tid, irq_events, wdata} = 16'hc000;
    {failures, check_count} = 0;
    cyc = shap_pkg::CYC_DATA_WR;
    mem[2] = 8'hee;
    for (int m = 0; m < 3; m++) begin
      mode = shap_pkg::link_mode_t'(m);
      core_status = 8'h5a ^ 8'(m);
      rst();
      wreg(8'h35, 8'ha5);
      rreg(8'h35);
      check(rdata, 8'ha5);
      xfer(shap_pkg::CYC_STAT_RD, 8'h00);
      check(rdata, core_status);
      wreg(shap_pkg::REG_MEM, 8'h11);
      xfer(shap_pkg::CYC_DATA_WR, 8'h22);
      // Written while busy, so this word must never land
      busy_font = 1'b1;
      xfer(shap_pkg::CYC_DATA_WR, 8'h33);
      busy_font = 1'b0;
      rreg(shap_pkg::REG_MEM);
      for (int i = 0; i < 3; i++) begin
        xfer(shap_pkg::CYC_DATA_RD, 8'h00);
        check(rdata, rd_exp[i]);
      end
      wreg(shap_pkg::REG_IRQ_EN, 8'h1f);
      for (int b = 0; b < 6; b++) begin
        if (b == 5) wreg(shap_pkg::REG_IRQ_EN, 8'h00);
        irq_events = 5'(1 << (b % 5));
        tick(1);
        irq_events = 5'h00;
        tick(3);
        check({7'h0, irq_n}, 8'(b / 5));
        rreg(shap_pkg::REG_IRQ_ST);
        check(rdata, 8'(1 << (b % 5)));
        wreg(shap_pkg::REG_IRQ_ST, 8'(1 << (b % 5)));
        rreg(shap_pkg::REG_IRQ_ST);
        check(rdata, 8'h00);
        check({7'h0, irq_n}, 8'h01);
      end
      for (int b = 0; b < 4; b++) begin
        {busy_bte, busy_clear, busy_font} = 3'(1 << b);
        tick(3);
        check({7'h0, wait_n}, 8'(b / 3));
      end
      if (mode == shap_pkg::MODE_I2C) begin
        tid = 2'b01;
        xfer(shap_pkg::CYC_STAT_RD, 8'h00);
        check({7'h0, rsp_nack}, 8'h01);
        {tid, i2c_fast} = 3'b100;
        xfer(shap_pkg::CYC_STAT_RD, 8'h00);
        check(rdata, core_status);
        check({7'h0, rsp_nack}, 8'h00);
        i2c_fast = 1'b1;
      end
      $display("mode %0d finished", m);
    end
    report_and_stop();
  end
endmodule
